// ==== hdl/cab_core.v ====
// Execution sequencer for skip, increment, OR and branch operations.
// Assumes an instruction issuer presents op_code with op_valid when
// op_ready is high; file data is read combinationally by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "cab_defs.vh"

module cab_core #(
  parameter PC_W = 13
) (
  input wire sys_clk,            // core clock, 200 MHz
  input wire rst_n,              // synchronous reset, active low
  input wire op_valid,           // instruction presented
  input wire [2:0] op_code,      // operation select
  input wire dest_sel,           // 0 working, 1 file
  input wire [10:0] op_literal,  // literal; low 8 bits for OR
  input wire [6:0] file_addr,    // addressed file register
  input wire [7:0] file_rdata,   // contents of addressed file
  input wire [7:0] upper_address_latch, // upper address latch
  output wire op_ready,          // can take an instruction
  output reg file_we_q,          // file write strobe
  output reg [6:0] file_waddr_q, // file write address
  output reg [7:0] file_wdata_q, // file write data
  output reg [7:0] work_q,       // working register
  output reg zero_flag_q,        // zero status flag
  output reg bubble_q,           // no-operation cycle marker
  output wire [PC_W-1:0] pc      // program counter
);
  localparam ST_EXEC = 2'b01;
  localparam ST_NOP = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  wire [7:0] result;
  wire is_zero;
  wire take;
  wire is_skip;
  wire is_branch;
  wire writes_dest;
  wire sets_zero;

  function is_skip_op;
    input [2:0] op;
    begin
      is_skip_op = (op == `CAB_OP_DEC_SKIP) || (op == `CAB_OP_INC_SKIP);
    end
  endfunction

  cab_alu u_alu (
    .op(op_code),
    .work_val(work_q),
    .file_val(file_rdata),
    .lit_val(op_literal[7:0]),
    .result(result),
    .is_zero(is_zero)
  );

  assign op_ready = (state_q == ST_EXEC);
  assign take = op_valid && op_ready;
  assign is_skip = is_skip_op(op_code);
  assign is_branch = (op_code == `CAB_OP_BRANCH);
  assign writes_dest = is_skip || (op_code == `CAB_OP_INC_FILE) ||
                       (op_code == `CAB_OP_OR_FILE);
  assign sets_zero = (op_code == `CAB_OP_INC_FILE) ||
                     (op_code == `CAB_OP_OR_LIT) ||
                     (op_code == `CAB_OP_OR_FILE);

  cab_pc #(
    .PC_W(PC_W)
  ) u_pc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .advance(take && !is_branch),
    .load(take && is_branch),
    .lit(op_literal),
    .latch(upper_address_latch),
    .pc_q(pc)
  );

  // Branch, and a skip whose result is zero, insert one dead cycle
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_EXEC: begin
        if (take && is_branch) begin
          state_d = ST_NOP;
        end else if (take && is_skip && is_zero) begin
          state_d = ST_NOP;
        end else begin
          state_d = ST_EXEC;
        end
      end
      ST_NOP: state_d = ST_EXEC;
      default: state_d = ST_EXEC;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_EXEC;
      bubble_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bubble_q <= (state_d == ST_NOP);
    end
  end

  // Result routing; skip ops leave the flag alone
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      work_q <= `CAB_RST_WORK;
      zero_flag_q <= `CAB_RST_ZERO;
      file_we_q <= 1'b0;
      file_waddr_q <= 7'h00;
      file_wdata_q <= 8'h00;
    end else begin
      file_we_q <= 1'b0;
      if (take && op_code == `CAB_OP_OR_LIT) begin
        work_q <= result;
      end else if (take && writes_dest) begin
        if (dest_sel == `CAB_DEST_FILE) begin
          file_we_q <= 1'b1;
          file_waddr_q <= file_addr;
          file_wdata_q <= result;
        end else begin
          work_q <= result;
        end
      end
      if (take && sets_zero) begin
        zero_flag_q <= is_zero;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/cab_defs.vh ====
// Constants for the arithmetic/branch execution block.
// Assumes inclusion by bare name from the design files.
`ifndef CAB_DEFS_VH
`define CAB_DEFS_VH

// Operation codes presented on op_code
`define CAB_OP_NONE 3'h0
`define CAB_OP_DEC_SKIP 3'h1
`define CAB_OP_INC_SKIP 3'h2
`define CAB_OP_INC_FILE 3'h3
`define CAB_OP_OR_LIT 3'h4
`define CAB_OP_OR_FILE 3'h5
`define CAB_OP_BRANCH 3'h6

// Destination select values
`define CAB_DEST_WORK 1'h0
`define CAB_DEST_FILE 1'h1

// Field positions
`define CAB_LIT_LSB 0
`define CAB_LIT_MSB 10
`define CAB_LATCH_LO 3
`define CAB_LATCH_HI 4
`define CAB_PC_UP_LO 11
`define CAB_PC_UP_HI 12

// Reset values
`define CAB_RST_WORK 8'h00
`define CAB_RST_PC 13'h0000
`define CAB_RST_ZERO 1'h0

`endif

// ==== hdl/cab_alu.v ====
// Result unit: increment, decrement and inclusive OR on 8-bit data.
// Assumes operands are stable in the cycle it is read; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "cab_defs.vh"

module cab_alu (
  input wire [2:0] op,       // operation code
  input wire [7:0] work_val, // working register value
  input wire [7:0] file_val, // addressed file register value
  input wire [7:0] lit_val,  // 8-bit literal
  output reg [7:0] result,   // operation result
  output wire is_zero        // result equals zero
);
  always @* begin
    case (op)
      `CAB_OP_DEC_SKIP: result = file_val - 8'h01;
      `CAB_OP_INC_SKIP: result = file_val + 8'h01;
      `CAB_OP_INC_FILE: result = file_val + 8'h01;
      `CAB_OP_OR_LIT: result = work_val | lit_val;
      `CAB_OP_OR_FILE: result = work_val | file_val;
      default: result = 8'h00;
    endcase
  end

  assign is_zero = (result == 8'h00);
endmodule
`default_nettype wire

// ==== hdl/cab_pc.v ====
// Program counter with branch load from literal and upper latch bits.
// Assumes advance and load are mutually exclusive per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "cab_defs.vh"

module cab_pc #(
  parameter PC_W = 13
) (
  input wire sys_clk,        // core clock
  input wire rst_n,          // synchronous reset, active low
  input wire advance,        // step to next instruction
  input wire load,           // branch load
  input wire [10:0] lit,     // branch literal
  input wire [7:0] latch,    // upper address latch
  output reg [PC_W-1:0] pc_q // program counter
);
  wire [PC_W-1:0] target;

  assign target = {latch[`CAB_LATCH_HI:`CAB_LATCH_LO],
                   lit[`CAB_LIT_MSB:`CAB_LIT_LSB]};

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pc_q <= `CAB_RST_PC;
    end else if (load) begin
      pc_q <= target;
    end else if (advance) begin
      pc_q <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// ==== dv/cab_monitor.sv ====
// Port checker for cab_core, bound to every instance.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cab_monitor #(parameter PC_W = 13) (
  input wire sys_clk,
  input wire rst_n,
  input wire op_valid,
  input wire [2:0] op_code,
  input wire dest_sel,
  input wire [10:0] op_literal,
  input wire [6:0] file_addr,
  input wire [7:0] file_rdata,
  input wire [7:0] upper_address_latch,
  input wire op_ready,
  input wire file_we_q,
  input wire [6:0] file_waddr_q,
  input wire [7:0] file_wdata_q,
  input wire [7:0] work_q,
  input wire zero_flag_q,
  input wire bubble_q,
  input wire [PC_W-1:0] pc
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire go = op_valid && op_ready;
  wire [2:0] o = op_code;
  branch_pc_a: assert property (go && o == 3'h6
    |=> pc == {$past(upper_address_latch[4:3]), $past(op_literal)})
    else $error("bad branch pc");
  branch_dead_a: assert property (go && o == 3'h6
    |=> !op_ready && bubble_q ##1 op_ready) else $error("bad branch gap");
  dec_skip_a: assert property (go && o == 3'h1 && file_rdata == 8'h01
    |=> !op_ready ##1 op_ready) else $error("no skip on zero");
  no_skip_a: assert property (go && o inside {3'h1, 3'h2}
    && file_rdata != 8'h01 && file_rdata != 8'hFF |=> op_ready)
    else $error("skip taken wrongly");
  skip_flag_a: assert property (go && o inside {3'h1, 3'h2}
    |=> $stable(zero_flag_q)) else $error("skip touched flag");
  file_dest_a: assert property (go && dest_sel && o inside {1, 2, 3, 5}
    |=> file_we_q && file_waddr_q == $past(file_addr))
    else $error("no file write");
  inc_work_a: assert property (go && o == 3'h3 && !dest_sel
    |=> work_q == $past(file_rdata) + 8'h01 && zero_flag_q == (work_q == 0))
    else $error("bad increment");
  or_lit_a: assert property (go && o == 3'h4
    |=> work_q == ($past(work_q) | $past(op_literal[7:0])))
    else $error("bad or literal");
  inc_skip_a: assert property (go && o == 3'h2 && file_rdata == 8'hFF
    |=> !op_ready ##1 op_ready) else $error("no increment skip");
  or_file_a: assert property (go && o == 3'h5 && !dest_sel
    |=> work_q == ($past(work_q) | $past(file_rdata)))
    else $error("bad or file");
  cover property (go && o == 3'h6);
  cover property (go && o == 3'h1 && file_rdata == 8'h01);
  cover property (go && o == 3'h5 && dest_sel);
  cover property (go && o == 3'h2 && file_rdata == 8'hFF);
endmodule
bind cab_core cab_monitor #(.PC_W(PC_W)) mon (.sys_clk, .rst_n, .op_valid,
  .op_code, .dest_sel, .op_literal, .file_addr, .file_rdata,
  .upper_address_latch, .op_ready, .file_we_q, .file_waddr_q,
  .file_wdata_q, .work_q, .zero_flag_q, .bubble_q, .pc);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for cab_core against a small reference model.
// Assumes the bound checker; one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "cab_defs.vh"
module tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, dest_sel = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [10:0] op_literal = 11'h000;
  logic [6:0] file_addr = 7'h00;
  logic [7:0] file_rdata = 8'h00, upper_address_latch = 8'h00;
  wire op_ready, file_we_q, zero_flag_q, bubble_q;
  wire [6:0] file_waddr_q;
  wire [7:0] file_wdata_q, work_q;
  wire [12:0] pc;
  logic [7:0] w_m = 8'h00, r;
  logic z_m = 1'b0;
  logic [12:0] pc_m = 13'h0000;
  logic [39:0] note_q[$], e;
  int n_errors = 0, num_checks = 0, cycles = 0;
  wire [39:0] seen = {work_q, zero_flag_q, pc, file_we_q,
    file_we_q ? file_wdata_q : 8'h00, op_ready, bubble_q,
    file_we_q ? file_waddr_q : 7'h00};
  cab_core uut (.sys_clk, .rst_n, .op_valid, .op_code, .dest_sel,
    .op_literal, .file_addr, .file_rdata, .upper_address_latch, .op_ready,
    .file_we_q, .file_waddr_q, .file_wdata_q, .work_q, .zero_flag_q,
    .bubble_q, .pc);
  initial forever #2.5 sys_clk = ~sys_clk;
  task check(input logic [39:0] s, input logic [39:0] x);
    num_checks++;
    if (s !== x) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task stop_test;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Called just after a clock edge; issues back to back
  task issue(input logic [2:0] o, input logic d, input logic [10:0] k,
    input logic [7:0] f, input logic [7:0] lat);
    logic we, dead;
    op_valid <= 1'b1;
    op_code <= o;
    dest_sel <= d;
    op_literal <= k;
    file_addr <= k[6:0];
    file_rdata <= f;
    upper_address_latch <= lat;
    we = d && o != `CAB_OP_OR_LIT && o != `CAB_OP_BRANCH;
    case (o)
      `CAB_OP_DEC_SKIP: r = f - 8'h01;
      `CAB_OP_OR_LIT: r = w_m | k[7:0];
      `CAB_OP_OR_FILE: r = w_m | f;
      default: r = f + 8'h01;
    endcase
    dead = o == `CAB_OP_BRANCH || (o < 3'h3 && r == 8'h00);
    if (o >= 3'h3 && o <= 3'h5) z_m = r == 8'h00;
    if (!we && o != `CAB_OP_BRANCH) w_m = r;
    pc_m = o == `CAB_OP_BRANCH ? {lat[4:3], k} : pc_m + 13'h0001;
    @(posedge sys_clk);
    note_q.push_back({w_m, z_m, pc_m, we, we ? r : 8'h00, !dead, dead,
      we ? k[6:0] : 7'h00});
    if (dead) begin
      op_valid <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  always @(negedge sys_clk) begin
    cycles++;
    if (cycles > 2000) begin
      n_errors++;
      stop_test;
    end
    while (note_q.size() > 0) begin
      e = note_q.pop_front();
      check(seen[39:17], e[39:17]);
      check(seen[16:0], e[16:0]);
    end
  end
  initial begin
    void'($urandom(35));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    issue(`CAB_OP_BRANCH, 1'b0, 11'h123, 8'h00, 8'h18);
    issue(`CAB_OP_DEC_SKIP, 1'b1, 11'h005, 8'h01, 8'h00);
    issue(`CAB_OP_INC_SKIP, 1'b0, 11'h006, 8'hFF, 8'h00);
    issue(`CAB_OP_OR_LIT, 1'b0, 11'h000, 8'h00, 8'h00);
    // Mid-run reset: every output except the masked file_wdata_q and file_waddr_q must fall back to its reset value
    rst_n <= 1'b0;
    op_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    note_q.push_back(40'h0000000100);
    rst_n <= 1'b1;
    w_m = 8'h00;
    z_m = 1'b0;
    pc_m = 13'h0000;
    issue(`CAB_OP_INC_SKIP, 1'b1, 11'h011, 8'h7F, 8'h00);
    repeat (300) issue(3'($urandom_range(6, 1)), 1'($urandom),
      11'($urandom), 8'($urandom), 8'($urandom));
    op_valid <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    stop_test;
  end
endmodule
`default_nettype wire
